// ---- core/ctfc_pkg.sv ----
/*
  Package for the CAN transceiver fault control block: register map, field positions,
  reset values, mode encodings and synchroniser depth.
  Assumes a 32-bit APB slave on the single 100 MHz device clock.
*/
package ctfc_pkg;

  localparam int unsigned CTFC_SYNC_STAGES = 3;

  // Register byte addresses.
  localparam logic [11:0] CTFC_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] CTFC_ADDR_STATUS = 12'h004;
  localparam logic [11:0] CTFC_ADDR_IRQ_ST = 12'h008;
  localparam logic [11:0] CTFC_ADDR_IRQ_EN = 12'h00C;
  localparam logic [11:0] CTFC_ADDR_IRQ_CL = 12'h010;

  // Control register fields.
  localparam int unsigned CTFC_CTRL_MODE_LSB = 0;
  localparam int unsigned CTFC_CTRL_RELEASE  = 4;
  localparam logic [1:0]  CTFC_MODE_RESET    = 2'h0;

  // Status register fields.
  localparam int unsigned CTFC_ST_OT_INH   = 0;
  localparam int unsigned CTFC_ST_CLP_INH  = 1;
  localparam int unsigned CTFC_ST_UV       = 2;
  localparam int unsigned CTFC_ST_SPLIT    = 3;
  localparam int unsigned CTFC_ST_MODE_LSB = 4;

  // Interrupt status, enable and clear bits share one layout.
  localparam int unsigned CTFC_IRQ_BUS = 0;
  localparam int unsigned CTFC_IRQ_CLP = 1;
  localparam int unsigned CTFC_IRQ_OT  = 2;
  localparam int unsigned CTFC_IRQ_UV  = 3;
  localparam int unsigned CTFC_IRQ_W   = 4;
  localparam logic [CTFC_IRQ_W-1:0] CTFC_IRQ_EN_RESET = 4'hF;

  typedef enum logic [1:0] {
    CTFC_MODE_OFF      = 2'h0,
    CTFC_MODE_WAKE     = 2'h1,
    CTFC_MODE_NORMAL   = 2'h2,
    CTFC_MODE_RX_ONLY  = 2'h3
  } ctfc_mode_t;

  typedef struct packed {
    logic over_temp;
    logic rxd_clamp;
    logic bus_short;
    logic supply_uv;
  } ctfc_fault_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ctfc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ctfc_apb_rsp_t;

endpackage

// ---- core/ctfc_sync.sv ----
/*
  Three-stage synchroniser for one asynchronous level; the output changes only once
  the second and third stages agree.
  Assumes the input may change at any time relative to clk_in.
*/
`timescale 1ns/1ps
module ctfc_sync
  import ctfc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      level_out
);

  logic [CTFC_SYNC_STAGES-1:0] stage_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[CTFC_SYNC_STAGES-2:0], async_in};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_out <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_out <= stage_q[2];
    end
  end

  a_sync_agree: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    stage_q[1] != stage_q[2] |=> $stable(level_out))
    else $error("Synchroniser output moved while its last stages disagreed.");

endmodule

// ---- core/ctfc_top.sv ----
/*
  Fault handling and mode control for a high-speed CAN transceiver cell: transmit gating
  on overtemperature and receive clamp, bus-short flagging, supply undervoltage, the
  common-mode stabiliser enable and an APB register file with a masked interrupt.
  Assumes analog detectors drive level flags asynchronously and the host MCU drives
  the transmit input from its own clock domain.
*/
`timescale 1ns/1ps
// Behaviour
// - Overtemperature blocks the transmitter so nothing is driven onto the bus.
// - Overtemperature never alters the programmed mode; recovery needs no software.
// - After cooling, transmit stays blocked until a dominant-to-recessive transmit edge.
// - A clamped recessive receive output is flagged and inhibits transmit while present.
// - Receive clamp inhibit is released only by a software command, never by itself.
// - Undervoltage comes from the supply rail monitor; host may switch the cell off.
// - Any CANH/CANL short to a supply sets the bus flag, interrupting unless masked.
// - A bus wiring failure leaves the transceiver mode unchanged.
// - Stabiliser output on in Normal and Receive Only, high impedance otherwise.
// - An unmasked failure interrupt drives the active-low interrupt output low.
module ctfc_top
  import ctfc_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  input  wire ctfc_apb_req_t apb_req_in,
  output ctfc_apb_rsp_t      apb_rsp_out,
  input  wire logic          txd_in,
  input  wire ctfc_fault_t   fault_in,
  output logic               txd_drive_out,
  output logic               driver_en_out,
  output logic               split_oe_n_out,
  output logic               int_n_out
);

  ctfc_fault_t fault_s;
  logic        txd_s;
  logic        txd_dom_s;
  logic        txd_prev_q;
  logic        ot_prev_q;
  logic        ot_inh_q;
  logic        clp_inh_q;
  ctfc_mode_t  mode_q;
  logic [CTFC_IRQ_W-1:0] irq_st_q;
  logic [CTFC_IRQ_W-1:0] irq_en_q;
  logic [CTFC_IRQ_W-1:0] irq_set;
  logic [CTFC_IRQ_W-1:0] irq_clr;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        release_cmd;
  logic        tx_block;
  logic        split_on;
  logic [31:0] prdata_q;

  // All asynchronous levels pass a three-stage synchroniser.
  ctfc_sync u_sync_ot (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (fault_in.over_temp),
    .level_out  (fault_s.over_temp)
  );
  ctfc_sync u_sync_clp (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (fault_in.rxd_clamp),
    .level_out  (fault_s.rxd_clamp)
  );
  ctfc_sync u_sync_bus (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (fault_in.bus_short),
    .level_out  (fault_s.bus_short)
  );
  ctfc_sync u_sync_uv (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (fault_in.supply_uv),
    .level_out  (fault_s.supply_uv)
  );
  // The transmit input idles recessive (high) while the synchroniser resets low, so it
  // carries the dominant level; reset then reads recessive and fakes no release edge.
  ctfc_sync u_sync_txd (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (~txd_in),
    .level_out  (txd_dom_s)
  );
  assign txd_s = ~txd_dom_s;

  // APB slave: zero wait states, every access completes in its access phase.
  assign wr_acc  = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;
  assign rd_acc  = apb_req_in.psel & apb_req_in.penable & ~apb_req_in.pwrite;
  always_comb begin
    case (apb_req_in.paddr)
      CTFC_ADDR_CTRL, CTFC_ADDR_STATUS, CTFC_ADDR_IRQ_ST,
      CTFC_ADDR_IRQ_EN, CTFC_ADDR_IRQ_CL: addr_ok = 1'b1;
      default:                            addr_ok = 1'b0;
    endcase
  end
  assign release_cmd = wr_acc && apb_req_in.paddr == CTFC_ADDR_CTRL
                       && apb_req_in.pwdata[CTFC_CTRL_RELEASE];

  // The mode changes only by software; no fault path writes it.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= ctfc_mode_t'(CTFC_MODE_RESET);
    end else if (wr_acc && apb_req_in.paddr == CTFC_ADDR_CTRL) begin
      mode_q <= ctfc_mode_t'(apb_req_in.pwdata[CTFC_CTRL_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txd_prev_q <= 1'b1;
      ot_prev_q  <= 1'b0;
    end else begin
      txd_prev_q <= txd_s;
      ot_prev_q  <= fault_s.over_temp;
    end
  end

  // Set while hot; cleared only by a rising (dominant-to-recessive) transmit edge
  // after the condition has gone, so a frame cut in mid-bit is not resumed.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ot_inh_q <= 1'b0;
    end else if (fault_s.over_temp) begin
      ot_inh_q <= 1'b1;
    end else if (txd_s && !txd_prev_q) begin
      ot_inh_q <= 1'b0;
    end
  end

  // Set while the clamp fault stands, released only by software; fault wins.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clp_inh_q <= 1'b0;
    end else if (fault_s.rxd_clamp) begin
      clp_inh_q <= 1'b1;
    end else if (release_cmd) begin
      clp_inh_q <= 1'b0;
    end
  end

  // Receive Only also keeps the driver off, as its definition requires.
  assign tx_block = ot_inh_q | clp_inh_q | (mode_q != CTFC_MODE_NORMAL);
  assign split_on = (mode_q == CTFC_MODE_NORMAL) | (mode_q == CTFC_MODE_RX_ONLY);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txd_drive_out  <= 1'b1;
      driver_en_out  <= 1'b0;
      split_oe_n_out <= 1'b1;
    end else begin
      txd_drive_out  <= tx_block ? 1'b1 : txd_s;
      driver_en_out  <= ~tx_block;
      split_oe_n_out <= ~split_on;
    end
  end

  // Sticky interrupt flags: a new event wins over a clear in the same cycle.
  always_comb begin
    irq_set = '0;
    irq_set[CTFC_IRQ_BUS] = fault_s.bus_short;
    irq_set[CTFC_IRQ_CLP] = fault_s.rxd_clamp;
    irq_set[CTFC_IRQ_OT]  = fault_s.over_temp & ~ot_prev_q;
    irq_set[CTFC_IRQ_UV]  = fault_s.supply_uv;
    irq_clr = '0;
    if (wr_acc && apb_req_in.paddr == CTFC_ADDR_IRQ_CL) begin
      irq_clr = apb_req_in.pwdata[CTFC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_en_q <= CTFC_IRQ_EN_RESET;
    end else if (wr_acc && apb_req_in.paddr == CTFC_ADDR_IRQ_EN) begin
      irq_en_q <= apb_req_in.pwdata[CTFC_IRQ_W-1:0];
    end
  end

  assign int_n_out = ~|(irq_st_q & irq_en_q);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_q <= '0;
    end else if (apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite) begin
      prdata_q <= '0;
      case (apb_req_in.paddr)
        CTFC_ADDR_CTRL:   prdata_q[CTFC_CTRL_MODE_LSB +: 2] <= mode_q;
        CTFC_ADDR_STATUS: begin
          prdata_q[CTFC_ST_OT_INH]        <= ot_inh_q;
          prdata_q[CTFC_ST_CLP_INH]       <= clp_inh_q;
          prdata_q[CTFC_ST_UV]            <= fault_s.supply_uv;
          prdata_q[CTFC_ST_SPLIT]         <= split_on;
          prdata_q[CTFC_ST_MODE_LSB +: 2] <= mode_q;
        end
        CTFC_ADDR_IRQ_ST: prdata_q[CTFC_IRQ_W-1:0] <= irq_st_q;
        CTFC_ADDR_IRQ_EN: prdata_q[CTFC_IRQ_W-1:0] <= irq_en_q;
        default:          prdata_q <= '0;
      endcase
    end
  end

  // One driver for the whole response keeps the registered and combinational parts apart.
  assign apb_rsp_out = '{prdata:  prdata_q,
                         pready:  1'b1,
                         pslverr: (wr_acc | rd_acc) & ~addr_ok};

  // Properties.
  sequence s_cooled_edge;
    !fault_s.over_temp && txd_s && !txd_prev_q;
  endsequence

  // A new overtemperature event, in the first cycle the synchronised level is high.
  sequence s_hot_rise;
    fault_s.over_temp && !ot_prev_q;
  endsequence

  // The release command only counts once the clamp fault itself has gone.
  sequence s_clamp_cleared;
    clp_inh_q && !fault_s.rxd_clamp && release_cmd;
  endsequence

  a_ot_blocks_tx: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.over_temp |=> ##1 (!driver_en_out && txd_drive_out))
    else $error("Transmitter active during overtemperature.");

  a_ot_hold_hot: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.over_temp |=> ot_inh_q)
    else $error("Overtemperature inhibit not held while hot.");

  a_ot_flag_rise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_hot_rise |=> irq_st_q[CTFC_IRQ_OT])
    else $error("Overtemperature event not recorded.");

  a_ot_keeps_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(fault_s.over_temp) && !wr_acc |=> mode_q == $past(mode_q))
    else $error("Overtemperature changed the mode.");

  a_mode_sw_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(wr_acc && apb_req_in.paddr == CTFC_ADDR_CTRL) |=> $stable(mode_q))
    else $error("Mode changed without a control write.");

  a_ot_auto_active: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !fault_s.over_temp && txd_s && !txd_prev_q && !fault_s.rxd_clamp && !clp_inh_q
    && !wr_acc && mode_q == CTFC_MODE_NORMAL |=> ##1 driver_en_out)
    else $error("Driver not re-enabled after cooling and a release edge.");

  a_ot_edge_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ot_inh_q && !fault_s.over_temp && !(txd_s && !txd_prev_q) |=> ot_inh_q)
    else $error("Overtemperature inhibit released without a transmit edge.");

  a_ot_release_done: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_cooled_edge |=> !ot_inh_q)
    else $error("Overtemperature inhibit not released after edge.");

  a_clamp_inhibit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.rxd_clamp |=> clp_inh_q ##1 !driver_en_out)
    else $error("Receive clamp did not inhibit the transmitter.");

  a_clamp_flag_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.rxd_clamp |=> irq_st_q[CTFC_IRQ_CLP])
    else $error("Receive clamp failure not recorded.");

  a_clamp_no_self: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clp_inh_q && !release_cmd |=> clp_inh_q)
    else $error("Receive clamp inhibit released without a command.");

  a_clamp_release_done: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_clamp_cleared |=> !clp_inh_q)
    else $error("Receive clamp inhibit not released by the command.");

  a_uv_flag_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.supply_uv |=> irq_st_q[CTFC_IRQ_UV])
    else $error("Undervoltage indication not recorded.");

  a_uv_keeps_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.supply_uv && !wr_acc |=> $stable(mode_q))
    else $error("Undervoltage changed the mode.");

  a_bus_flag_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.bus_short && irq_en_q[CTFC_IRQ_BUS] && !wr_acc
    |=> irq_st_q[CTFC_IRQ_BUS] && !int_n_out)
    else $error("Bus failure not flagged or interrupt not raised.");

  a_bus_flag_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_st_q[CTFC_IRQ_BUS] && !irq_clr[CTFC_IRQ_BUS] |=> irq_st_q[CTFC_IRQ_BUS])
    else $error("Bus failure flag lost without a clear.");

  a_bus_flag_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_clr[CTFC_IRQ_BUS] && !fault_s.bus_short |=> !irq_st_q[CTFC_IRQ_BUS])
    else $error("Bus failure flag not cleared.");

  a_bus_keeps_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.bus_short && !wr_acc |=> $stable(mode_q))
    else $error("Bus failure changed the mode.");

  a_bus_no_inhibit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    fault_s.bus_short && !tx_block && !fault_s.over_temp && !fault_s.rxd_clamp
    && !wr_acc |=> !tx_block)
    else $error("Bus failure blocked the transmitter.");

  a_split_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ##1 split_oe_n_out == !($past(mode_q) == CTFC_MODE_NORMAL
                         || $past(mode_q) == CTFC_MODE_RX_ONLY))
    else $error("Stabiliser enable does not match the mode.");

  a_split_off_hiz: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode_q == CTFC_MODE_OFF || mode_q == CTFC_MODE_WAKE |=> split_oe_n_out)
    else $error("Stabiliser driven in Off or Wake Capable mode.");

  a_split_on_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode_q == CTFC_MODE_NORMAL || mode_q == CTFC_MODE_RX_ONLY |=> !split_oe_n_out)
    else $error("Stabiliser not driven in Normal or Receive Only mode.");

  a_int_active_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_st_q[CTFC_IRQ_BUS] && irq_en_q[CTFC_IRQ_BUS] |-> !int_n_out)
    else $error("Unmasked bus failure does not pull the interrupt low.");

  a_tx_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !tx_block |=> txd_drive_out == $past(txd_s))
    else $error("Effective transmit does not follow the input.");

  a_blocked_recessive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tx_block |=> txd_drive_out)
    else $error("Blocked transmit is not recessive.");

  a_blocked_no_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    tx_block |=> !driver_en_out)
    else $error("Driver enabled while transmit is blocked.");

  a_drive_enabled: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !tx_block |=> driver_en_out)
    else $error("Driver disabled while nothing blocks transmit.");

endmodule

// ---- tb/ctfc_host_model.sv ----
/*
  Host controller and bus model: drives the transmit input and watches its own echo.
  Assumes the bench sets the wanted bit and a flag that shorts CANH to CANL.
*/
`timescale 1ns/1ps
module ctfc_host_model (
  input  wire logic clk_in,
  input  wire logic send_dom_in,
  input  wire logic hl_short_in,
  input  wire logic txd_drive_in,
  input  wire logic driver_en_in,
  output logic      txd_out,
  output logic      echo_bad_out
);
  logic       rxd;
  logic [3:0] miss_q = 4'h0;
  assign txd_out = ~send_dom_in;
  // A CANH-to-CANL short keeps the bus recessive whatever the driver does.
  assign rxd = ~(driver_en_in & ~txd_drive_in & ~hl_short_in);
  // The device never reports that short, so the host must compare its own echo.
  always_ff @(posedge clk_in) begin
    if (txd_out == rxd) begin
      miss_q <= 4'h0;
    end else if (miss_q != 4'hF) begin
      miss_q <= miss_q + 4'h1;
    end
  end
  assign echo_bad_out = (miss_q == 4'hF);
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the transceiver fault control block with an APB master.
  Assumes the APB slave answers in time and fault latencies of a few clock edges.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import ctfc_pkg::*;
  logic          clk_in;
  logic          reset_n_in;
  logic          send_dom;
  logic          hl_short;
  logic          txd;
  logic          echo_bad;
  logic          txd_drive;
  logic          drv_en;
  logic          split_oe_n;
  logic          int_n;
  logic          err;
  logic [31:0]   rd;
  ctfc_apb_req_t req;
  ctfc_apb_rsp_t rsp;
  ctfc_fault_t   flt;
  int            errors;
  int            comparisons;

  ctfc_top uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .apb_req_in(req),
    .apb_rsp_out(rsp), .txd_in(txd), .fault_in(flt), .txd_drive_out(txd_drive),
    .driver_en_out(drv_en), .split_oe_n_out(split_oe_n), .int_n_out(int_n));
  ctfc_host_model host (.clk_in(clk_in), .send_dom_in(send_dom), .hl_short_in(hl_short),
    .txd_drive_in(txd_drive), .driver_en_in(drv_en), .txd_out(txd),
    .echo_bad_out(echo_bad));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Entered just after a rising edge; leaves one idle edge so requests never collide.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk_in);
  endtask

  task automatic close_out();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    `CHK({txd_drive, drv_en, split_oe_n, int_n}, 4'hB)
    apb(CTFC_ADDR_IRQ_EN, 1'b0, 32'h0);
    `CHK(rd, 32'h0000000F)
    apb(12'h014, 1'b1, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    apb(CTFC_ADDR_CTRL, 1'b0, 32'h0);
    `CHK(rd, 32'h00000000)
    $display("reset test finished");
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      apb(CTFC_ADDR_CTRL, 1'b1, 32'(m));
      cyc(2);
      `CHK(split_oe_n, 1'(m < 2))
      `CHK(drv_en, 1'(m == 2))
      apb(CTFC_ADDR_STATUS, 1'b0, 32'h0);
      `CHK(rd[5:3], {2'(m), 1'(m >= 2)})
    end
    $display("mode test finished");
  endtask

  task automatic t_ot();
    apb(CTFC_ADDR_CTRL, 1'b1, 32'h2);
    send_dom <= 1'b1;
    cyc(8);
    `CHK({txd_drive, drv_en}, 2'b01)
    flt.over_temp <= 1'b1;
    cyc(8);
    `CHK({txd_drive, drv_en}, 2'b10)
    apb(CTFC_ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rd[5:0], 6'h29)
    flt.over_temp <= 1'b0;
    cyc(8);
    `CHK(drv_en, 1'b0)
    send_dom <= 1'b0;
    cyc(8);
    `CHK(drv_en, 1'b1)
    send_dom <= 1'b1;
    cyc(8);
    `CHK(txd_drive, 1'b0)
    `CHK(echo_bad, 1'b0)
    send_dom <= 1'b0;
    apb(CTFC_ADDR_IRQ_ST, 1'b0, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(CTFC_ADDR_IRQ_CL, 1'b1, 32'hF);
    $display("overtemperature test finished");
  endtask

  task automatic t_clamp();
    flt.rxd_clamp <= 1'b1;
    cyc(8);
    `CHK(drv_en, 1'b0)
    apb(CTFC_ADDR_CTRL, 1'b1, 32'h12);
    cyc(4);
    `CHK(drv_en, 1'b0)
    flt.rxd_clamp <= 1'b0;
    cyc(8);
    `CHK(drv_en, 1'b0)
    apb(CTFC_ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rd[1], 1'b1)
    apb(CTFC_ADDR_CTRL, 1'b1, 32'h12);
    cyc(3);
    `CHK(drv_en, 1'b1)
    apb(CTFC_ADDR_CTRL, 1'b0, 32'h0);
    `CHK(rd[4:0], 5'h02)
    apb(CTFC_ADDR_IRQ_CL, 1'b1, 32'hF);
    $display("clamp test finished");
  endtask

  task automatic t_bus();
    flt.bus_short <= 1'b1;
    cyc(8);
    flt.bus_short <= 1'b0;
    cyc(8);
    `CHK(int_n, 1'b0)
    `CHK(drv_en, 1'b1)
    apb(CTFC_ADDR_IRQ_ST, 1'b0, 32'h0);
    `CHK(rd[3:0], 4'h1)
    apb(CTFC_ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rd[5:4], 2'h2)
    apb(CTFC_ADDR_IRQ_EN, 1'b1, 32'hE);
    `CHK(int_n, 1'b1)
    apb(CTFC_ADDR_IRQ_CL, 1'b1, 32'h1);
    apb(CTFC_ADDR_IRQ_EN, 1'b1, 32'hF);
    `CHK(int_n, 1'b1)
    $display("bus failure test finished");
  endtask

  task automatic t_uv_short();
    hl_short <= 1'b1;
    send_dom <= 1'b1;
    cyc(24);
    `CHK(echo_bad, 1'b1)
    apb(CTFC_ADDR_IRQ_ST, 1'b0, 32'h0);
    `CHK(rd[3:0], 4'h0)
    send_dom <= 1'b0;
    hl_short <= 1'b0;
    flt.supply_uv <= 1'b1;
    cyc(8);
    apb(CTFC_ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(CTFC_ADDR_CTRL, 1'b1, 32'h0);
    cyc(2);
    `CHK({split_oe_n, drv_en}, 2'b10)
    $display("undervoltage and echo test finished");
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    reset_n_in <= 1'b0;
    req <= '0;
    flt <= '0;
    send_dom <= 1'b0;
    hl_short <= 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_modes();
    t_ot();
    t_clamp();
    t_bus();
    t_uv_short();
    close_out();
  end

  // The tests need a few hundred cycles at most; this margin only stops a hang.
  initial begin
    #100us;
    errors++;
    close_out();
  end
endmodule
